// ---- slf_checker.sv ----
// Port assertions for static forwarding
`timescale 1ns/10ps
`default_nettype none
module slf_checker (input wire pclk, presetn, psel, penable, pwrite, pslverr, input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata, input wire [3:0] pstrb, input wire [7:0] static_en, chan_valid,
  chan_ready, route_valid);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase and register window hit
  wire acc = psel & penable, hit = paddr[11:5] == 7'h14;
  property p_en; acc & pwrite & hit & pstrb[3] |=> static_en[$past(paddr[4:2])] == $past(pwdata[31]); endproperty
  a_en: assert property (p_en) else $error("enable not stored");
  property p_rd; acc & !pwrite & hit |-> {prdata[31:5], pslverr} == {static_en[paddr[4:2]], 27'h0}; endproperty
  a_rd: assert property (p_rd) else $error("bad readback");
  property p_um; acc & !hit |-> {pslverr, prdata} == {1'b1, 32'h0}; endproperty
  a_um: assert property (p_um) else $error("unmapped accepted");
  property p_ex; (chan_valid & route_valid) == 8'h00; endproperty
  a_ex: assert property (p_ex) else $error("beat on both paths");
  property p_hd; chan_valid[0] & !chan_ready[0] |=> chan_valid[0]; endproperty
  a_hd: assert property (p_hd) else $error("static beat dropped");
endmodule
bind slf_static_fwd slf_checker CHK (.*);
`default_nettype wire

// ---- slf_defs.vh ----
// Constants for the static link forwarding block
`ifndef SLF_DEFS_VH
`define SLF_DEFS_VH
// Register indices; byte address is four times the index
`define SLF_IDX_FIRST 10'h0a0
`define SLF_IDX_LAST 10'h0a7
`define SLF_NUM_LINKS 8
// Field layout
`define SLF_EN_BIT 31
`define SLF_DEST_MSB 4
`define SLF_DEST_W 5
// Reset values
`define SLF_EN_RST 1'b0
`define SLF_DEST_RST 5'h00
`endif

// ---- slf_far_end.sv ----
// Link sources and channel end sinks
`timescale 1ns/10ps
`default_nettype none
module slf_far_end (input wire logic pclk, stall, input wire logic [7:0] go, rx_ready,
  output logic [7:0] rx_valid = 8'h00, output logic [63:0] rx_data, output logic [7:0] chan_ready);
  // Beat offered until taken; idle lanes invert so stale data never matches
  always @(posedge pclk) rx_valid <= go | rx_valid & ~rx_ready;
  always_comb for (int i = 0; i < 8; i++) rx_data[8*i+:8] = rx_valid[i] ? 8'h30+8'(i) : ~(8'h30+8'(i));
  assign chan_ready = {8{~stall}};
endmodule
`default_nettype wire

// ---- slf_static_fwd.v ----
// Static link forwarding: per-link config registers and packet steering
//
// Functional notes
// - Bit 31 enables static mode, resets zero
// - Static link packets bypass routing to channel
// - Bits 4:0 select destination channel end
// - Eight registers, links C,D,A,B,G,H,E,F
//
// Register map: eight words, word index 0xa0 to 0xa7, and the byte
// address is four times the index (0x280 to 0x29c).
//   bit 31     enable static forwarding for the link
//   bits 30:5  reserved, read as zero, writes dropped
//   bits 4:0   destination channel end on this node
//
// Bus timing: pready is tied high, so every access is one setup
// cycle and one access cycle. Read data is registered during setup
// so prdata comes from a flop; writes commit at the access edge.
//
// Link side: one register stage per link. A beat taken on
// rx_valid & rx_ready shows up on the static or the routed outputs
// in the next cycle and stands there until its sink is ready.
// Mode and destination are latched on the first beat of a packet,
// so reconfiguring a busy link never splits a packet in two.
//
// Limitation: the decode reads paddr[11:2] directly, so an ADDR_W
// below 12 is not supported without changing the decode.
// Trade-off: one stage per link gives full rate only while the
// sink keeps ready high; a stalled sink back-pressures the link.
`timescale 1ns/10ps
`default_nettype none
`include "slf_defs.vh"

module slf_static_fwd #(
  parameter DATA_W = 8,
  parameter ADDR_W = 12
) (
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Link receivers, slot i = register i (C,D,A,B,G,H,E,F)
  input wire [7:0] rx_valid,
  input wire [8*DATA_W-1:0] rx_data,
  input wire [7:0] rx_last,
  output wire [7:0] rx_ready,
  // Static path to local channel ends
  output wire [7:0] chan_valid,
  output wire [8*DATA_W-1:0] chan_data,
  output wire [8*`SLF_DEST_W-1:0] chan_dest,
  output wire [7:0] chan_last,
  input wire [7:0] chan_ready,
  // Normal routed path into the switch
  output wire [7:0] route_valid,
  output wire [8*DATA_W-1:0] route_data,
  output wire [7:0] route_last,
  input wire [7:0] route_ready,
  // Current static enable bits, for observation
  output wire [7:0] static_en
);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  // Width of the reserved gap between enable and destination
  localparam RSV_W = `SLF_EN_BIT - `SLF_DEST_W;

  wire [9:0] word_idx;
  wire hit;
  wire [2:0] sel_link;
  wire acc_phase;
  wire setup_phase;
  reg [7:0] en_r;
  reg [8*`SLF_DEST_W-1:0] dest_r;

  // Destination field of one link, picked out of the packed vector
  function [`SLF_DEST_W-1:0] dest_of;
    input [8*`SLF_DEST_W-1:0] vec;
    input [2:0] idx;
    begin
      dest_of = vec[idx*`SLF_DEST_W +: `SLF_DEST_W];
    end
  endfunction

  // Read word of one link; reserved middle bits are always zero
  function [31:0] read_word;
    input en;
    input [`SLF_DEST_W-1:0] dest;
    begin
      read_word = {en, {RSV_W{1'b0}}, dest};
    end
  endfunction

  // Word index from byte address; byte lanes below the word are ignored
  assign word_idx = paddr[11:2];
  assign hit = (word_idx >= `SLF_IDX_FIRST) && (word_idx <= `SLF_IDX_LAST);
  assign sel_link = word_idx[2:0];
  // Bus phases, shared by the write, read and error logic
  assign acc_phase = psel & penable;
  assign setup_phase = psel & ~penable;
  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = acc_phase & ~hit;
  assign static_en = en_r;

  // Config writes, committed in the access phase only
  // Enable and destination sit in different byte lanes, so each
  // is gated by its own strobe and a partial write leaves the other
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= {8{`SLF_EN_RST}};
      dest_r <= {8{`SLF_DEST_RST}};
    end else if (acc_phase && pwrite && hit) begin
      if (pstrb[3]) begin
        en_r[sel_link] <= pwdata[`SLF_EN_BIT];
      end
      if (pstrb[0]) begin
        dest_r[sel_link*`SLF_DEST_W +: `SLF_DEST_W] <= pwdata[`SLF_DEST_MSB:0];
      end
    end
  end

  // Read data prepared in setup so it is a flop in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase) begin
      // Writes and misses return zero so no stale word leaks out
      if (!pwrite && hit) begin
        prdata <= read_word(en_r[sel_link], dest_of(dest_r, sel_link));
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-link steering
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `SLF_NUM_LINKS; gi = gi + 1) begin : g_link
      reg in_pkt_r;
      reg pkt_static_r;
      reg [`SLF_DEST_W-1:0] pkt_dest_r;
      reg out_valid_r;
      reg out_static_r;
      reg out_last_r;
      reg [DATA_W-1:0] out_data_r;
      reg [`SLF_DEST_W-1:0] out_dest_r;
      wire cur_static;
      wire [`SLF_DEST_W-1:0] cur_dest;
      wire out_take;
      wire in_take;
      // Link number of this slot, in the width of the decode
      localparam [2:0] LINK = gi;

      // Mode is frozen per packet so a config change never splits one
      assign cur_static = in_pkt_r ? pkt_static_r : en_r[gi];
      assign cur_dest = in_pkt_r ? pkt_dest_r : dest_of(dest_r, LINK);
      assign out_take = out_valid_r & (out_static_r ? chan_ready[gi] : route_ready[gi]);
      assign in_take = rx_valid[gi] & rx_ready[gi];
      assign rx_ready[gi] = ~out_valid_r | out_take;

      // Static beats go only to the channel side; no route is asked for
      assign chan_valid[gi] = out_valid_r & out_static_r;
      assign route_valid[gi] = out_valid_r & ~out_static_r;
      assign chan_data[gi*DATA_W +: DATA_W] = out_data_r;
      assign route_data[gi*DATA_W +: DATA_W] = out_data_r;
      assign chan_last[gi] = out_last_r;
      assign route_last[gi] = out_last_r;
      assign chan_dest[gi*`SLF_DEST_W +: `SLF_DEST_W] = out_dest_r;

      // Packet tracking
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          in_pkt_r <= 1'b0;
          pkt_static_r <= 1'b0;
          pkt_dest_r <= `SLF_DEST_RST;
        end else if (in_take) begin
          in_pkt_r <= ~rx_last[gi];
          pkt_static_r <= cur_static;
          pkt_dest_r <= cur_dest;
        end
      end

      // One output stage per link
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          out_valid_r <= 1'b0;
          out_static_r <= 1'b0;
          out_last_r <= 1'b0;
          out_data_r <= {DATA_W{1'b0}};
          out_dest_r <= `SLF_DEST_RST;
        end else if (in_take) begin
          out_valid_r <= 1'b1;
          out_static_r <= cur_static;
          out_last_r <= rx_last[gi];
          out_data_r <= rx_data[gi*DATA_W +: DATA_W];
          out_dest_r <= cur_dest;
        end else if (out_take) begin
          out_valid_r <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ---- test_static_link_forwarding.sv ----
// Static forwarding bench
`timescale 1ns/10ps
`default_nettype none
module test_static_link_forwarding;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stall = 1, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [7:0] go = 8'h00;
  wire pready, pslverr;
  wire [31:0] prdata;
  wire [7:0] rx_valid, rx_ready, chan_valid, chan_ready, route_valid, static_en;
  wire [63:0] rx_data, chan_data, route_data;
  wire [7:0] chan_last, route_last;
  wire [39:0] chan_dest;
  int fail_count = 0, num_checks = 0;
  slf_static_fwd DUT (.*, .pstrb(4'hf), .rx_last(8'hff), .route_ready(chan_ready));
  slf_far_end FAR (.*);
  // 50 MHz clock
  initial forever #10 pclk = ~pclk;
  task chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin fail_count++; $display("CHECK FAILED %0t got %h", $time, g); end
  endtask
  task end_sim;
    $display("%0d checks %0d fails", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task apb(input logic w, input logic [9:0] i, input logic [31:0] d);
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, i, 2'b00, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr; {psel, penable} <= 2'b00;
  endtask
  task t_regs;
    apb(0, 10'h0a0, 0); chk(rd, 0);
    for (int i = 0; i < 8; i++) begin
      apb(1, 10'h0a0 + i, {~i[0], 26'h3ffffff, 5'(i + 9)});
      apb(0, 10'h0a0 + i, 0); chk(rd, {~i[0], 26'h0, 5'(i + 9)});
      chk(err, 0);
    end
    apb(1, 10'h0a8, 32'hffffffff); chk(err, 1);
    apb(0, 10'h09f, 0); chk({err, rd[30:0]}, 32'h80000000);
    chk(static_en, 8'h55);
  endtask
  task t_fwd;
    @(posedge pclk) go <= 8'hff;
    @(posedge pclk) go <= 8'h00;
    repeat (2) @(posedge pclk);
    chk({chan_valid, route_valid}, 16'h55aa);
    chk({chan_dest[24:20], chan_data[39:32]}, {5'h0d, 8'h34});
    chk({chan_last, route_last, route_data[15:8]}, 24'hffff31);
    stall <= 0;
    repeat (2) @(posedge pclk);
    chk({chan_valid, route_valid}, 0);
  endtask
  // Main sequence after a 12-cycle reset
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_fwd;
    end_sim;
  end
  // Watchdog, far beyond the roughly 75 cycles needed
  initial begin #100us; fail_count++; end_sim; end
endmodule
`default_nettype wire
